// ===== logic/irc_pkg.sv
package irc_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFS   = 8'h00; // serial_main_control
  localparam logic [7:0] RATE_OFS   = 8'h04; // multiplier + rate code
  localparam logic [7:0] STAT_OFS   = 8'h08; // sticky event status
  localparam logic [7:0] MASK_OFS   = 8'h0C; // event mask
  localparam logic [7:0] ACT_OFS    = 8'h10; // block state readback
  localparam logic [7:0] CNT_OFS    = 8'h14; // bit period (divider times multiplier)
  // ==========================================================
  // control fields
  localparam int EN_BIT   = 7;
  localparam int IE_BIT   = 6;
  localparam int MST_BIT  = 5;
  localparam int TX_BIT   = 4;
  localparam int ACK_BIT  = 3;
  localparam int RS_BIT   = 2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [2:0] MASK_RST = 3'h0;
  // status bits
  localparam int EV_START = 0;
  localparam int EV_STOP  = 1;
  localparam int EV_ARBL  = 2;
  // ==========================================================
  // rate table entry: divider, sda hold, start hold, stop hold
  typedef struct packed {
    logic [11:0] div;
    logic [9:0]  sda;
    logic [10:0] sth;
    logic [10:0] sph;
  } irc_rate_t;
  typedef enum logic [1:0] {IRC_IDLE, IRC_START, IRC_BUSY, IRC_STOP}
    irc_state_t;
  localparam logic [1:0] RATE_MULTIPLIER_FIELD_RSVD = 2'h3;
endpackage

// ===== logic/irc_rate_ctrl.sv
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
// Function
// - each rate code maps to divider, holds
// - code 3F is slowest: 3840/513/1918/1921
// - control bit 7 enables the module
// - control bit 6 gates interrupt request
// - master bit rising makes start condition
// - master bit falling makes stop condition
// - control bit 4 selects transmit direction
// - ack cycle drives SDA from bit 3
// - repeated start bit while master restarts
// - repeated start bit always reads zero
// - misplaced repeated start reports arbitration loss
// - bit rate is clock over rate_multiplier_field times divider
// - multiplier field 00/01/10 gives 1/2/4
// - holds scale by multiplier times count
module irc_rate_ctrl
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic        ack_cycle,
  output logic             transmit_dir,
  output logic             irq
);
  // ==========================================================
  // rate lookup
  function automatic irc_pkg::irc_rate_t rate_lut(input logic [5:0] c);
    irc_pkg::irc_rate_t t;
    t = '{12'd20, 10'd7, 11'd6, 11'd11};
    unique case (c)
      6'h00: t = '{12'd20, 10'd7, 11'd6, 11'd11};
      6'h01: t = '{12'd22, 10'd7, 11'd7, 11'd12};
      6'h02: t = '{12'd24, 10'd8, 11'd8, 11'd13};
      6'h03: t = '{12'd26, 10'd8, 11'd9, 11'd14};
      6'h04: t = '{12'd28, 10'd9, 11'd10, 11'd15};
      6'h05: t = '{12'd30, 10'd9, 11'd11, 11'd16};
      6'h06: t = '{12'd34, 10'd10, 11'd13, 11'd18};
      6'h07: t = '{12'd40, 10'd10, 11'd16, 11'd21};
      6'h08: t = '{12'd28, 10'd7, 11'd10, 11'd15};
      6'h09: t = '{12'd32, 10'd7, 11'd12, 11'd17};
      6'h0A: t = '{12'd36, 10'd9, 11'd14, 11'd19};
      6'h0B: t = '{12'd40, 10'd9, 11'd16, 11'd21};
      6'h0C: t = '{12'd44, 10'd11, 11'd18, 11'd23};
      6'h0D: t = '{12'd48, 10'd11, 11'd20, 11'd25};
      6'h0E: t = '{12'd56, 10'd13, 11'd24, 11'd29};
      6'h0F: t = '{12'd68, 10'd13, 11'd30, 11'd35};
      6'h10: t = '{12'd48, 10'd9, 11'd18, 11'd25};
      6'h11: t = '{12'd56, 10'd9, 11'd22, 11'd29};
      6'h12: t = '{12'd64, 10'd13, 11'd26, 11'd33};
      6'h13: t = '{12'd72, 10'd13, 11'd30, 11'd37};
      6'h14: t = '{12'd80, 10'd17, 11'd34, 11'd41};
      6'h15: t = '{12'd88, 10'd17, 11'd38, 11'd45};
      6'h16: t = '{12'd104, 10'd21, 11'd46, 11'd53};
      6'h17: t = '{12'd128, 10'd21, 11'd58, 11'd65};
      6'h18: t = '{12'd80, 10'd9, 11'd38, 11'd41};
      6'h19: t = '{12'd96, 10'd9, 11'd46, 11'd49};
      6'h1A: t = '{12'd112, 10'd17, 11'd54, 11'd57};
      6'h1B: t = '{12'd128, 10'd17, 11'd62, 11'd65};
      6'h1C: t = '{12'd144, 10'd25, 11'd70, 11'd73};
      6'h1D: t = '{12'd160, 10'd25, 11'd78, 11'd81};
      6'h1E: t = '{12'd192, 10'd33, 11'd94, 11'd97};
      6'h1F: t = '{12'd240, 10'd33, 11'd118, 11'd121};
      6'h20: t = '{12'd160, 10'd17, 11'd78, 11'd81};
      6'h21: t = '{12'd192, 10'd17, 11'd94, 11'd97};
      6'h22: t = '{12'd224, 10'd33, 11'd110, 11'd113};
      6'h23: t = '{12'd256, 10'd33, 11'd126, 11'd129};
      6'h24: t = '{12'd288, 10'd49, 11'd142, 11'd145};
      6'h25: t = '{12'd320, 10'd49, 11'd158, 11'd161};
      6'h26: t = '{12'd384, 10'd65, 11'd190, 11'd193};
      6'h27: t = '{12'd480, 10'd65, 11'd238, 11'd241};
      6'h28: t = '{12'd320, 10'd33, 11'd158, 11'd161};
      6'h29: t = '{12'd384, 10'd33, 11'd190, 11'd193};
      6'h2A: t = '{12'd448, 10'd65, 11'd222, 11'd225};
      6'h2B: t = '{12'd512, 10'd65, 11'd254, 11'd257};
      6'h2C: t = '{12'd576, 10'd97, 11'd286, 11'd289};
      6'h2D: t = '{12'd640, 10'd97, 11'd318, 11'd321};
      6'h2E: t = '{12'd768, 10'd129, 11'd382, 11'd385};
      6'h2F: t = '{12'd960, 10'd129, 11'd478, 11'd481};
      6'h30: t = '{12'd640, 10'd65, 11'd318, 11'd321};
      6'h31: t = '{12'd768, 10'd65, 11'd382, 11'd385};
      6'h32: t = '{12'd896, 10'd129, 11'd446, 11'd449};
      6'h33: t = '{12'd1024, 10'd129, 11'd510, 11'd513};
      6'h34: t = '{12'd1152, 10'd193, 11'd574, 11'd577};
      6'h35: t = '{12'd1280, 10'd193, 11'd638, 11'd641};
      6'h36: t = '{12'd1536, 10'd257, 11'd766, 11'd769};
      6'h37: t = '{12'd1920, 10'd257, 11'd958, 11'd961};
      6'h38: t = '{12'd1280, 10'd129, 11'd638, 11'd641};
      6'h39: t = '{12'd1536, 10'd129, 11'd766, 11'd769};
      6'h3A: t = '{12'd1792, 10'd257, 11'd894, 11'd897};
      6'h3B: t = '{12'd2048, 10'd257, 11'd1022, 11'd1025};
      6'h3C: t = '{12'd2304, 10'd385, 11'd1150, 11'd1153};
      6'h3D: t = '{12'd2560, 10'd385, 11'd1278, 11'd1281};
      6'h3E: t = '{12'd3072, 10'd513, 11'd1534, 11'd1537};
      6'h3F: t = '{12'd3840, 10'd513, 11'd1918, 11'd1921};
    endcase
    return t;
  endfunction

  // ==========================================================
  // registers
  logic [7:0]  ctrl_r;
  logic [7:0]  rate_r;
  logic [2:0]  stat_r;
  logic [2:0]  mask_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  irc_pkg::irc_state_t st_r;
  logic [14:0] tick_r;
  logic [14:0] hold_r;
  logic        scl_drv_r;
  logic        sda_drv_r;
  logic        rs_pend_r;
  logic        slv_ack_r;

  // ==========================================================
  // decode
  wire irc_pkg::irc_rate_t ent = rate_lut(rate_r[5:0]);
  wire [1:0]  rate_multiplier_field_f   = rate_r[7:6];
  wire [2:0]  rate_multiplier_field_val = (rate_multiplier_field_f == 2'h1) ? 3'd2 :
                         (rate_multiplier_field_f == 2'h2) ? 3'd4 : 3'd1;
  wire [14:0] bit_per  = 15'(ent.div * rate_multiplier_field_val);
  wire [14:0] sda_hold = 15'(ent.sda * rate_multiplier_field_val);
  wire [14:0] st_hold  = 15'(ent.sth * rate_multiplier_field_val);
  wire [14:0] sp_hold  = 15'(ent.sph * rate_multiplier_field_val);
  wire        en       = ctrl_r[irc_pkg::EN_BIT];
  wire        wr_fire  = aw_got_r && w_got_r && !s_axi_bvalid;
  wire        wr_ctrl  = wr_fire && awaddr_r == irc_pkg::CTRL_OFS
                         && wstrb_r[0];
  wire        wr_rate  = wr_fire && awaddr_r == irc_pkg::RATE_OFS
                         && wstrb_r[0];
  wire        wr_stat  = wr_fire && awaddr_r == irc_pkg::STAT_OFS
                         && wstrb_r[0];
  wire        wr_mask  = wr_fire && awaddr_r == irc_pkg::MASK_OFS
                         && wstrb_r[0];
  wire        wr_map   = awaddr_r == irc_pkg::CTRL_OFS ||
                         awaddr_r == irc_pkg::RATE_OFS ||
                         awaddr_r == irc_pkg::STAT_OFS ||
                         awaddr_r == irc_pkg::MASK_OFS;
  wire        mst_old  = ctrl_r[irc_pkg::MST_BIT];
  wire        mst_new  = wdata_r[irc_pkg::MST_BIT];
  wire        go_start = wr_ctrl && wdata_r[irc_pkg::EN_BIT] && !mst_old
                         && mst_new;
  wire        go_stop  = wr_ctrl && mst_old && !mst_new;
  wire        rs_req   = wr_ctrl && wdata_r[irc_pkg::RS_BIT];
  wire        rs_ok    = rs_req && mst_old && mst_new
                         && st_r == irc_pkg::IRC_BUSY;
  wire        rs_bad   = rs_req && !rs_ok;
  wire        lost_arb = rs_bad && mst_old;
  wire        hold_end = hold_r == 15'h0000;
  wire [2:0]  ev_set;
  assign ev_set = {rs_bad,
                   st_r == irc_pkg::IRC_STOP && hold_end,
                   st_r == irc_pkg::IRC_START && hold_end};

  // ==========================================================
  // axi write side
  assign s_axi_awready = !aw_got_r;
  assign s_axi_wready  = !w_got_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h00000000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_got_r)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && !w_got_r)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? 2'h0 : 2'h2; // slverr if unmapped
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi read side
  wire [7:0]  rd_a    = {s_axi_araddr[7:2], 2'h0};
  wire [31:0] rd_data =
    rd_a == irc_pkg::CTRL_OFS ? {24'h000000, ctrl_r} :
    rd_a == irc_pkg::RATE_OFS ? {24'h000000, rate_r} :
    rd_a == irc_pkg::STAT_OFS ? {29'h00000000, stat_r} :
    rd_a == irc_pkg::MASK_OFS ? {29'h00000000, mask_r} :
    rd_a == irc_pkg::ACT_OFS  ? {28'h0000000, rs_pend_r, st_r, en} :
    rd_a == irc_pkg::CNT_OFS  ? {17'h00000, bit_per} : 32'h00000000;
  wire        rd_map  = rd_a <= irc_pkg::CNT_OFS;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_map ? 2'h0 : 2'h2;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================
  // control, rate, status, mask registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= irc_pkg::CTRL_RST;
      rate_r <= irc_pkg::RATE_RST;
      stat_r <= 3'h0;
      mask_r <= irc_pkg::MASK_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= {wdata_r[7:6], mst_new && !lost_arb, wdata_r[4:3], 1'b0,
                   wdata_r[1:0]};
      if (wr_rate)
        rate_r <= wdata_r[7:0];
      if (wr_mask)
        mask_r <= wdata_r[2:0];
      // set wins over write-one-to-clear
      stat_r <= (stat_r & ~(wr_stat ? wdata_r[2:0] : 3'h0)) | ev_set;
    end
  end

  // ==========================================================
  // start / stop / repeated start sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (!en && !go_start))
    begin
      st_r      <= irc_pkg::IRC_IDLE;
      tick_r    <= 15'h0000;
      hold_r    <= 15'h0000;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
      rs_pend_r <= 1'b0;
      slv_ack_r <= 1'b0;
    end
    else
    begin
      tick_r <= (st_r == irc_pkg::IRC_BUSY && tick_r + 15'h0001 < bit_per)
                ? tick_r + 15'h0001 : 15'h0000;
      // slave receiver answers the ack cycle from the control bit
      slv_ack_r <= !mst_old && ack_cycle && !ctrl_r[irc_pkg::ACK_BIT];
      if (rs_ok)
        rs_pend_r <= 1'b1;
      unique case (st_r)
        irc_pkg::IRC_IDLE:
          if (go_start || rs_pend_r)
          begin
            st_r      <= irc_pkg::IRC_START;
            sda_drv_r <= 1'b1;
            hold_r    <= st_hold - 15'h0001; // zero is the last cycle
            rs_pend_r <= 1'b0;
          end
        irc_pkg::IRC_START:
          if (hold_end)
          begin
            st_r      <= irc_pkg::IRC_BUSY;
            scl_drv_r <= 1'b1;
          end
          else
            hold_r <= hold_r - 15'h0001;
        irc_pkg::IRC_BUSY:
          if (go_stop)
          begin
            st_r      <= irc_pkg::IRC_STOP;
            scl_drv_r <= 1'b0;
            sda_drv_r <= 1'b1;
            hold_r    <= sp_hold - 15'h0001;
          end
          else if (rs_pend_r)
          begin
            st_r      <= irc_pkg::IRC_IDLE; // release then restart
            scl_drv_r <= 1'b0;
            sda_drv_r <= 1'b0;
          end
          else if (ack_cycle)
          begin
            // sda changes one hold after scl low
            if (tick_r == sda_hold)
              sda_drv_r <= !ctrl_r[irc_pkg::ACK_BIT];
          end
        irc_pkg::IRC_STOP:
          if (hold_end)
          begin
            st_r      <= irc_pkg::IRC_IDLE;
            sda_drv_r <= 1'b0;
          end
          else
            hold_r <= hold_r - 15'h0001;
      endcase
      if (lost_arb) // arbitration lost releases both lines
      begin
        st_r      <= irc_pkg::IRC_IDLE;
        scl_drv_r <= 1'b0;
        sda_drv_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // pins and interrupt
  assign scl_out      = 1'b0;
  assign sda_out      = 1'b0;
  assign scl_oe_n     = !scl_drv_r;
  assign sda_oe_n     = !(sda_drv_r || slv_ack_r);
  assign transmit_dir = ctrl_r[irc_pkg::TX_BIT];
  assign irq = ctrl_r[irc_pkg::IE_BIT] && |(stat_r & mask_r);
endmodule // irc_rate_ctrl

// ===== testbench/irc_rate_props.sv
`timescale 1ns/1ps
module irc_rate_props
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        scl_oe_n,
  input wire logic        sda_oe_n,
  input wire logic        ack_cycle,
  input wire logic        transmit_dir,
  input wire logic        irq
);
  // ==========================================================
  // shadow of the control register and quiet time since a write
  logic [7:0] aw_a_r;
  logic [7:0] ar_a_r;
  logic [7:0] wd_r;
  logic [7:0] ctl_r;
  logic [2:0] quiet_r;
  wire        aw_hs = s_axi_awvalid && s_axi_awready;
  wire        b_hs  = s_axi_bvalid && s_axi_bready;
  // address and data latches
  always_ff @(posedge aclk)
  begin
    if (aw_hs)
      aw_a_r <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
      wd_r <= s_axi_wdata[7:0];
    if (s_axi_arvalid && s_axi_arready)
      ar_a_r <= s_axi_araddr;
  end
  // control copy updates when the write response is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctl_r <= 8'h00;
    else if (b_hs && aw_a_r == irc_pkg::CTRL_OFS)
      ctl_r <= wd_r;
    if (!aresetn || aw_hs || b_hs)
      quiet_r <= 3'h0;
    else if (quiet_r != 3'h7)
      quiet_r <= quiet_r + 3'h1;
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rs_reads_zero: assert property (
    s_axi_rvalid && ar_a_r == irc_pkg::CTRL_OFS |-> !s_axi_rdata[2])
    else $error("repeated start bit read back as one");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not valid one cycle after address");
  a_unmapped_err: assert property (
    s_axi_rvalid && ar_a_r > irc_pkg::CNT_OFS |-> s_axi_rresp == 2'h2)
    else $error("unmapped read did not return slave error");
  a_irq_gated: assert property (
    quiet_r == 3'h7 && !ctl_r[6] |-> !irq)
    else $error("interrupt raised while interrupts disabled");
  a_off_released: assert property (
    quiet_r == 3'h7 && !ctl_r[7] |-> scl_oe_n && sda_oe_n)
    else $error("bus line pulled while module disabled");
  a_slave_scl_free: assert property (
    quiet_r == 3'h7 && !ctl_r[5] |-> scl_oe_n)
    else $error("clock line pulled outside master operation");
  a_dir_follows: assert property (
    quiet_r == 3'h7 |-> transmit_dir == ctl_r[4])
    else $error("direction output differs from control bit");
  a_nack_quiet: assert property (
    quiet_r == 3'h7 && ack_cycle && ctl_r[3] && !ctl_r[5] |-> sda_oe_n)
    else $error("acknowledge driven while no-acknowledge chosen");
  a_start_hold: assert property (
    $fell(sda_oe_n) && scl_oe_n && !ack_cycle |-> scl_oe_n [*5])
    else $error("clock pulled too soon after start");
  a_stop_hold: assert property (
    $rose(scl_oe_n) && !sda_oe_n |-> !sda_oe_n [*8])
    else $error("data released too soon after clock release");
  // main scenarios
  c_start: cover property ($fell(sda_oe_n) && scl_oe_n);
  c_irq: cover property ($rose(irq));
  c_ack: cover property (ack_cycle && !sda_oe_n);
endmodule // irc_rate_props
bind irc_rate_ctrl irc_rate_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .ack_cycle(ack_cycle),
  .transmit_dir(transmit_dir), .irq(irq));

// ===== testbench/irc_bus_peer.sv
`timescale 1ns/1ps
module irc_bus_peer
(
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  output logic     scl,
  output logic     sda
);
  // ==========================================================
  // open-drain lines with pull-ups: released lines read high
  assign scl = scl_oe_n;
  assign sda = sda_oe_n;
endmodule // irc_bus_peer

// ===== testbench/irc_rate_ctrl_bench.sv
`timescale 1ns/1ps
module irc_rate_ctrl_bench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, scl_in, scl_out;
  logic        scl_oe_n, sda_in, sda_out, sda_oe_n, ack_cycle;
  logic        transmit_dir, irq, lo;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp_seen;
  int          mismatches, check_count, hold_b, i;
  int          hold_n = 0;
  // rate settings and bit periods: 20 68 144 3840 7680 15360 3840
  logic [7:0]  rate_code [7] = '{8'h00, 8'h0F, 8'h1C, 8'h3F, 8'h7F,
                                 8'hBF, 8'hFF};
  logic [31:0] rate_per [7] = '{32'h14, 32'h44, 32'h90, 32'hF00,
                                32'h1E00, 32'h3C00, 32'hF00};
  // ==========================================================
  // device and bus peer
  irc_rate_ctrl i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .ack_cycle(ack_cycle),
    .transmit_dir(transmit_dir), .irq(irq));
  irc_bus_peer u_peer (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
                       .scl(scl_in), .sda(sda_in));
  always #5 aclk = ~aclk;
  // cycles with clock released and data pulled: start or stop hold
  always @(posedge aclk)
    if (scl_oe_n === 1'b1 && sda_oe_n === 1'b0)
      hold_n <= hold_n + 1;
  // ==========================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    resp_seen = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    rd_data = s_axi_rdata;
    resp_seen = s_axi_rresp;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    rd(a);
    chk(nm, e, rd_data);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial
  begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
    {s_axi_arvalid, s_axi_rready, ack_cycle} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(irc_pkg::CTRL_OFS, 32'h0, "ctrl reset");
    rc(irc_pkg::MASK_OFS, 32'h0, "mask reset");
    for (i = 0; i < 7; i++)
    begin
      wr(irc_pkg::RATE_OFS, {24'h0, rate_code[i]});
      rc(irc_pkg::CNT_OFS, rate_per[i], "bit period");
    end
    wr(8'h20, 32'h1);
    chk("write resp", 32'h2, {30'h0, resp_seen});
    rd(8'h20);
    chk("read resp", 32'h2, {30'h0, resp_seen});
    wr(irc_pkg::RATE_OFS, 32'h40);
    hold_b = hold_n;
    wr(irc_pkg::CTRL_OFS, 32'hB0);
    repeat (40) @(posedge aclk);
    chk("start hold", 32'hC, hold_n - hold_b);
    rc(irc_pkg::STAT_OFS, 32'h1, "start status");
    wr(irc_pkg::CTRL_OFS, 32'hB4);
    repeat (100) @(posedge aclk);
    rc(irc_pkg::STAT_OFS, 32'h1, "restart status");
    rc(irc_pkg::CTRL_OFS, 32'hB0, "restart ctrl");
    hold_b = hold_n;
    wr(irc_pkg::CTRL_OFS, 32'h80);
    repeat (60) @(posedge aclk);
    chk("stop hold", 32'h16, hold_n - hold_b);
    rc(irc_pkg::STAT_OFS, 32'h3, "stop status");
    wr(irc_pkg::CTRL_OFS, 32'h84);
    rc(irc_pkg::STAT_OFS, 32'h7, "arb status");
    rc(irc_pkg::CTRL_OFS, 32'h80, "arb ctrl");
    wr(irc_pkg::MASK_OFS, 32'h4);
    wr(irc_pkg::CTRL_OFS, 32'hC0);
    repeat (3) @(posedge aclk);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(irc_pkg::CTRL_OFS, 32'h80);
    repeat (3) @(posedge aclk);
    chk("irq gated", 32'h0, {31'h0, irq});
    wr(irc_pkg::CTRL_OFS, 32'hC0);
    wr(irc_pkg::STAT_OFS, 32'h7);
    rc(irc_pkg::STAT_OFS, 32'h0, "status cleared");
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(irc_pkg::CTRL_OFS, 32'h90);
    repeat (3) @(posedge aclk);
    chk("transmit", 32'h1, {31'h0, transmit_dir});
    for (i = 0; i < 2; i++)
    begin
      wr(irc_pkg::CTRL_OFS, i ? 32'h88 : 32'h80);
      ack_cycle <= 1'b1;
      lo = 1'b0;
      repeat (60)
      begin
        @(posedge aclk);
        if (sda_oe_n === 1'b0)
          lo = 1'b1;
      end
      ack_cycle <= 1'b0;
      chk("ack drive", i ? 32'h0 : 32'h1, {31'h0, lo});
    end
    chk("receive", 32'h0, {31'h0, transmit_dir});
    wr(irc_pkg::CTRL_OFS, 32'hB0);
    repeat (4) @(posedge aclk);
    wr(irc_pkg::CTRL_OFS, 32'h30);
    repeat (3) @(posedge aclk);
    chk("lines off", 32'h3, {30'h0, scl_oe_n, sda_oe_n});
    wr(irc_pkg::CTRL_OFS, 32'h10);
    hold_b = hold_n;
    wr(irc_pkg::CTRL_OFS, 32'h30);
    repeat (40) @(posedge aclk);
    chk("no start off", 32'h0, hold_n - hold_b);
    give_verdict;
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    give_verdict;
  end
endmodule // irc_rate_ctrl_bench
